// ===== rtl/port_defs.svh
`ifndef PORT_DEFS_SVH
`define PORT_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DIR_IDX          16'hFFD1
`define DATA_IDX         16'hFFD3
`define MUX_IDX          16'hFFD5
`define STAT_IDX         16'hFFD7

// ----------------------------------------------------------------
// reset and read-back values
// ----------------------------------------------------------------
`define DIR_RST_MODE12   8'h00
`define DIR_RST_MODE34   8'h80
`define DATA_RST         8'h00
`define MUX_RST          5'h00
`define DIR_READ_VAL     8'hFF
`define RDATA_ZERO       32'h0000_0000

// ----------------------------------------------------------------
// operating mode codes and field positions
// ----------------------------------------------------------------
`define MODE_3           3'h3
`define MODE_4           3'h4
`define PIN7             7
`define MUX_SEL_TOP      2
`define MUX_PWM_BIT      3
`define MUX_PAT_BIT      4
`define STAT_MODE34_BIT  5

`endif

// ===== rtl/port_pkg.sv
package port_pkg;

    // ----------------------------------------------------------------
    // shared types
    // ----------------------------------------------------------------
    typedef logic [7:0] reg8_t;   // one port byte

    // who drives the top pin, one-hot
    typedef enum logic [4:0] {
        SRC_INPUT   = 5'b0_0001,
        SRC_PORT    = 5'b0_0010,
        SRC_PATTERN = 5'b0_0100,
        SRC_TIMER   = 5'b0_1000,
        SRC_ADDR    = 5'b1_0000
    } pin7_src_t;

endpackage : port_pkg

// ===== rtl/pin_sync.sv
module pin_sync #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    // ----------------------------------------------------------------
    // two-stage synchroniser; first stage feeds only the second
    // ----------------------------------------------------------------
    logic [W-1:0] meta_r;   // may go metastable, never read by logic

    // both stages clear on reset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end

endmodule : pin_sync

// ===== rtl/port_mux_top.sv
// Summary of operation
// [RULE1] eight pins, direction bit one means output
// [RULE2] modes 3/4: pin 7 is address bit 20
// [RULE3] direction register reads back all ones
// [RULE4] reset direction 00 or 80 by mode
// [RULE5] software standby keeps direction register
// [RULE6] data read: latch if output, else pin
// [RULE7] data cleared on reset, kept in standby (code also clears it in hardware standby, keeps it in software standby)
// [RULE8] modes 1/2 pin 7: input, data, pattern
// [RULE9] timer compare output overrides pin 7
// [RULE10] capture input from pin 7 when selected
// [RULE11] select 001..011 means timer owns pin
//
// Register access over Avalon-MM was chosen for this implementation.
`include "port_defs.svh"

module port_mux_top (
    input  wire logic           I_CORE_CLK,
    input  wire logic           I_RST_N,
    input  wire logic [17:0]    I_AVS_ADDRESS,
    input  wire logic           I_AVS_READ,
    input  wire logic           I_AVS_WRITE,
    input  wire logic [31:0]    I_AVS_WRITEDATA,
    input  wire logic [3:0]     I_AVS_BYTEENABLE,
    output logic      [31:0]    O_AVS_READDATA,
    output logic                O_AVS_WAITREQUEST,
    input  wire logic [2:0]     I_MODE,
    input  wire logic           I_HW_STANDBY_N,
    input  wire logic           I_SW_STANDBY,
    input  wire logic           I_ADDR_BIT20,
    input  wire logic           I_TIMER2_IO_B_OUT,
    input  wire logic           I_PATTERN_OUTPUT_BIT7,
    input  wire port_pkg::reg8_t I_PORT_PIN_IN,
    output port_pkg::reg8_t     O_PORT_PIN_OUT,
    output port_pkg::reg8_t     O_PORT_PIN_OE,
    output logic                O_TIMER2_IO_B_CAPTURE
);
    import port_pkg::*;

    // ----------------------------------------------------------------
    // synchronisers for everything arriving from pins
    // ----------------------------------------------------------------
    reg8_t      pin_s;          // pin levels, two flops late
    logic [3:0] strap_s;        // {standby_n, mode}
    logic [2:0] mode_s;         // synchronised mode pins
    logic       hw_stby;        // hardware standby, active high
    logic       mode34;         // address mode, pin 7 is address

    pin_sync #(.W(8)) u_pin_sync (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RST_N),
        .i_async (I_PORT_PIN_IN),
        .o_sync  (pin_s)
    );

    pin_sync #(.W(4)) u_strap_sync (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RST_N),
        .i_async ({I_HW_STANDBY_N, I_MODE}),
        .o_sync  (strap_s)
    );

    assign mode_s  = strap_s[2:0];
    // sync stages reset to zero, so standby reads active until valid
    assign hw_stby = ~strap_s[3];
    assign mode34  = (mode_s == `MODE_3) || (mode_s == `MODE_4);

    // ----------------------------------------------------------------
    // initial load after reset release
    // ----------------------------------------------------------------
    logic init_r;   // high until the mode pins have been seen

    // clears one edge after standby is seen inactive, so the
    // mode-dependent load below uses settled mode pins
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            init_r <= 1'b1;
        end else if (hw_stby) begin
            init_r <= 1'b1;
        end else begin
            init_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // avalon slave: decode and one wait state
    // ----------------------------------------------------------------
    logic [15:0] word_idx;    // register index from byte address
    logic        req;         // read or write pending
    logic        ack_r;       // answer cycle, waitrequest low
    logic        hit_dir;
    logic        hit_data;
    logic        hit_mux;
    logic        hit_stat;
    logic        wr_go;       // write takes effect this edge
    logic        rd_cap;      // read data captured this edge

    assign word_idx = I_AVS_ADDRESS[17:2];
    assign req      = I_AVS_READ | I_AVS_WRITE;
    assign hit_dir  = (word_idx == `DIR_IDX);
    assign hit_data = (word_idx == `DATA_IDX);
    assign hit_mux  = (word_idx == `MUX_IDX);
    assign hit_stat = (word_idx == `STAT_IDX);
    // only the low byte lane carries register bits
    assign wr_go    = I_AVS_WRITE & ack_r & I_AVS_BYTEENABLE[0]
                      & ~I_SW_STANDBY & ~hw_stby;
    assign rd_cap   = I_AVS_READ & ~ack_r & ~init_r;

    assign O_AVS_WAITREQUEST = req & ~ack_r;

    // ack rises one cycle after the request, held off during init
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r & ~init_r;
        end
    end

    // ----------------------------------------------------------------
    // direction register
    // ----------------------------------------------------------------
    reg8_t ddr_r;     // stored direction bits
    reg8_t ddr_eff;   // direction as the pins see it

    // [RULE4] mode-dependent reset
    // [RULE5] no other update, so software standby retains it
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ddr_r <= `DIR_RST_MODE12;
        end else if (hw_stby || init_r) begin
            ddr_r <= mode34 ? `DIR_RST_MODE34 : `DIR_RST_MODE12;
        end else if (wr_go && hit_dir) begin
            // [RULE2] bit 7 write ignored
            ddr_r <= mode34 ? {1'b1, I_AVS_WRITEDATA[6:0]}
                            : I_AVS_WRITEDATA[7:0];
        end
    end

    // [RULE2] bit 7 forced while address mode
    always_comb begin
        ddr_eff         = ddr_r;
        ddr_eff[`PIN7]  = ddr_r[`PIN7] | mode34;
    end

    // ----------------------------------------------------------------
    // data register
    // ----------------------------------------------------------------
    reg8_t data_r;   // latched output data

    // [RULE7] cleared on reset and hardware standby, retained otherwise
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            data_r <= `DATA_RST;
        end else if (hw_stby) begin
            data_r <= `DATA_RST;
        end else if (wr_go && hit_data) begin
            data_r <= I_AVS_WRITEDATA[7:0];
        end
    end

    // ----------------------------------------------------------------
    // pin-7 function control (timer select, pwm, pattern enable)
    // ----------------------------------------------------------------
    logic [4:0] mux_r;     // {pattern en, pwm, select[2:0]}
    logic       tmr_own;   // timer drives pin 7 as compare output
    logic       cap_sel;   // pin 7 routed to capture input

    // software standby also keeps this control state
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            mux_r <= `MUX_RST;
        end else if (hw_stby) begin
            mux_r <= `MUX_RST;
        end else if (wr_go && hit_mux) begin
            mux_r <= I_AVS_WRITEDATA[4:0];
        end
    end

    // [RULE11] selections 001..011 are compare output
    assign tmr_own = ~mux_r[`MUX_SEL_TOP] & (mux_r[1:0] != 2'b00);
    // [RULE10] top select bit set and pwm off
    assign cap_sel = mux_r[`MUX_SEL_TOP] & ~mux_r[`MUX_PWM_BIT];

    // ----------------------------------------------------------------
    // pin-7 source selection
    // ----------------------------------------------------------------
    pin7_src_t src7;   // current owner of pin 7

    // priority: address mode, timer, then direction and pattern
    always_comb begin
        if (mode34) begin
            // [RULE2] address output
            src7 = SRC_ADDR;
        end else if (tmr_own) begin
            // [RULE9] timer overrides direction
            src7 = SRC_TIMER;
        end else if (!ddr_r[`PIN7]) begin
            // [RULE8] plain input
            src7 = SRC_INPUT;
        end else if (mux_r[`MUX_PAT_BIT]) begin
            // [RULE8] pattern output
            src7 = SRC_PATTERN;
        end else begin
            src7 = SRC_PORT;
        end
    end

    // ----------------------------------------------------------------
    // pin drivers, registered
    // ----------------------------------------------------------------
    reg8_t pin_out_nxt;
    reg8_t pin_oe_nxt;

    // [RULE1] pins 6..0 follow direction and data
    always_comb begin
        pin_out_nxt = data_r;
        pin_oe_nxt  = ddr_eff;
        unique case (src7)
            SRC_ADDR: begin
                pin_out_nxt[`PIN7] = I_ADDR_BIT20;
                pin_oe_nxt[`PIN7]  = 1'b1;
            end
            SRC_TIMER: begin
                pin_out_nxt[`PIN7] = I_TIMER2_IO_B_OUT;
                pin_oe_nxt[`PIN7]  = 1'b1;
            end
            SRC_PATTERN: begin
                pin_out_nxt[`PIN7] = I_PATTERN_OUTPUT_BIT7;
                pin_oe_nxt[`PIN7]  = 1'b1;
            end
            SRC_PORT: begin
                pin_out_nxt[`PIN7] = data_r[`PIN7];
                pin_oe_nxt[`PIN7]  = 1'b1;
            end
            SRC_INPUT: begin
                pin_out_nxt[`PIN7] = data_r[`PIN7];
                pin_oe_nxt[`PIN7]  = 1'b0;
            end
        endcase
        // hardware standby floats every pin
        if (hw_stby) begin
            pin_oe_nxt = '0;
        end
    end

    // one cycle of latency buys glitch-free pin drive
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_PORT_PIN_OUT <= '0;
            O_PORT_PIN_OE  <= '0;
        end else begin
            O_PORT_PIN_OUT <= pin_out_nxt;
            O_PORT_PIN_OE  <= pin_oe_nxt;
        end
    end

    // [RULE10] capture path, gated when not selected
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_TIMER2_IO_B_CAPTURE <= 1'b0;
        end else begin
            O_TIMER2_IO_B_CAPTURE <= cap_sel & pin_s[`PIN7];
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [31:0] rdata_nxt;
    reg8_t       port_view;   // what a data read returns

    // [RULE6] latch for outputs, pin level for inputs
    assign port_view = (ddr_eff & data_r) | (~ddr_eff & pin_s);

    // unmapped indices read zero
    always_comb begin
        rdata_nxt = `RDATA_ZERO;
        if (hit_dir) begin
            // [RULE3] write-only, reads all ones
            rdata_nxt[7:0] = `DIR_READ_VAL;
        end else if (hit_data) begin
            rdata_nxt[7:0] = port_view;
        end else if (hit_mux) begin
            rdata_nxt[4:0] = mux_r;
        end else if (hit_stat) begin
            rdata_nxt[4:0] = src7;
            rdata_nxt[`STAT_MODE34_BIT] = mode34;
        end
    end

    // captured in the wait cycle, stands through the answer cycle
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_AVS_READDATA <= `RDATA_ZERO;
        end else if (rd_cap) begin
            O_AVS_READDATA <= rdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);

    a_wait_one_cycle: assert property (
        (req && !ack_r && !init_r) |=> !O_AVS_WAITREQUEST)
        else $error("answer not one cycle after request");

    a_dir_reads_ones: assert property ( // [RULE3]
        (rd_cap && hit_dir) |=> (O_AVS_READDATA == 32'h0000_00FF))
        else $error("direction read not all ones");

    a_data_read_mix: assert property ( // [RULE6]
        (rd_cap && hit_data) |=>
        (O_AVS_READDATA[7:0] == $past(port_view)))
        else $error("data read mixes wrong sources");

    a_mode34_addr_pin: assert property ( // [RULE2]
        (mode34 && !hw_stby) |=>
        (O_PORT_PIN_OE[7] && O_PORT_PIN_OUT[7] == $past(I_ADDR_BIT20)))
        else $error("pin 7 not address in mode 3/4");

    a_dir_bit7_held: assert property ( // [RULE2]
        (mode34 && !init_r && !hw_stby) |-> ddr_r[`PIN7])
        else $error("direction bit 7 not held");

    a_dir_reset_mode: assert property ( // [RULE4]
        (hw_stby || init_r) |=>
        (ddr_r == ($past(mode34) ? 8'h80 : 8'h00)))
        else $error("direction reset value wrong");

    a_data_reset: assert property ( // [RULE7]
        hw_stby |=> (data_r == 8'h00))
        else $error("data not cleared in standby");

    a_sw_stby_keep: assert property ( // [RULE5]
        (I_SW_STANDBY && !hw_stby && !init_r) |=>
        ($stable(ddr_r) && $stable(data_r)))
        else $error("registers changed in software standby");

    a_timer_pin7: assert property ( // [RULE9]
        (!mode34 && tmr_own && !hw_stby) |=>
        (O_PORT_PIN_OE[7] && O_PORT_PIN_OUT[7] == $past(I_TIMER2_IO_B_OUT)))
        else $error("timer does not drive pin 7");

    a_pattern_pin7: assert property ( // [RULE8]
        (src7 == SRC_PATTERN && !hw_stby) |=>
        (O_PORT_PIN_OUT[7] == $past(I_PATTERN_OUTPUT_BIT7)))
        else $error("pattern bit not on pin 7");

    a_input_pin7: assert property ( // [RULE8]
        (!mode34 && !tmr_own && !ddr_r[`PIN7]) |=> !O_PORT_PIN_OE[7])
        else $error("pin 7 driven while input");

    a_capture_route: assert property ( // [RULE10]
        !cap_sel |=> !O_TIMER2_IO_B_CAPTURE)
        else $error("capture active while not selected");

    a_pins_follow_dir: assert property ( // [RULE1]
        !hw_stby |=> (O_PORT_PIN_OE[6:0] == $past(ddr_r[6:0])))
        else $error("pin enables differ from direction");

    c_dir_write:  cover property (wr_go && hit_dir);
    c_pattern:    cover property (src7 == SRC_PATTERN);
    c_timer_own:  cover property (src7 == SRC_TIMER);
    c_capture:    cover property (O_TIMER2_IO_B_CAPTURE);

endmodule : port_mux_top

// ===== verif/pin_partner.sv
// ----------------------------------------------------------------
// outside circuit on the port pins
// ----------------------------------------------------------------
module pin_partner
    import port_pkg::*;
(
    input  wire reg8_t i_pin_out,   // values the port drives
    input  wire reg8_t i_pin_oe,    // high where the port drives
    input  wire reg8_t i_ext,       // what the outside circuit drives
    output reg8_t      o_level      // resolved wire level per pin
);
    // a pin the port drives shows its value; elsewhere the outside
    // circuit drives, so no line is ever left floating to an x
    assign o_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);
endmodule : pin_partner

// ===== verif/tb.sv
`include "port_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import port_pkg::*;

    // ----------------------------------------------------------------
    // stimulus and observation signals
    // ----------------------------------------------------------------
    logic        clk, rst_n, rd, wr, hw_n, sw_sb, a20, tmr, pat;
    logic [17:0] addr;          // byte address on the bus
    logic [31:0] wdata, rdata;  // bus data both ways
    logic [3:0]  be;            // byte enables
    logic [2:0]  mode;          // operating mode pins
    logic        wreq, cap;     // waitrequest and capture route
    reg8_t       ext, pout, poe, lvl;
    int          n_errors, checks_done, k;
    logic [31:0] seed, r;
    logic [7:0]  dir_m, data_m; // reference register contents
    logic        m34, own, eoe, eout;
    pin7_src_t   src;

    port_mux_top dut_u (.I_CORE_CLK(clk), .I_RST_N(rst_n),
        .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
        .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq),
        .I_MODE(mode), .I_HW_STANDBY_N(hw_n), .I_SW_STANDBY(sw_sb),
        .I_ADDR_BIT20(a20), .I_TIMER2_IO_B_OUT(tmr),
        .I_PATTERN_OUTPUT_BIT7(pat), .I_PORT_PIN_IN(lvl),
        .O_PORT_PIN_OUT(pout), .O_PORT_PIN_OE(poe),
        .O_TIMER2_IO_B_CAPTURE(cap));

    pin_partner far_u (.i_pin_out(pout), .i_pin_oe(poe), .i_ext(ext),
        .o_level(lvl));

    // ----------------------------------------------------------------
    // clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // whole run needs well under 1500 cycles; this is a wide margin
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        results();
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xrand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xrand

    // expected port read: latch where output, pin level where input
    function automatic logic [31:0] port_exp();
        logic [7:0] de;
        de = dir_m | (m34 ? 8'h80 : 8'h00);
        return {24'h00_0000, (data_m & de) | (ext & ~de)};
    endfunction : port_exp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one bus transfer; held until waitrequest is seen low at an edge
    task automatic av(input logic w, input logic [15:0] idx,
                      input logic [7:0] d, output logic [31:0] qd);
        int n;
        n = 0;
        @(posedge clk);
        addr  <= {idx, 2'b00};
        wr    <= w;
        rd    <= ~w;
        wdata <= {24'h00_0000, d};
        // waitrequest is looked at on the rising edge itself, before
        // the design's own updates of that edge land
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (n >= 50) n_errors++;
        qd = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : av

    task automatic wreg(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] t;
        av(1'b1, idx, d, t);
    endtask : wreg

    task automatic rdchk(input logic [15:0] idx, input logic [31:0] e);
        logic [31:0] t;
        av(1'b0, idx, 8'h00, t);
        chk(t, e);
    endtask : rdchk

    // let registered outputs and the pin synchronisers land
    task automatic settle();
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic do_reset(input logic [2:0] m);
        @(posedge clk);
        mode  <= m;
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        m34    = (m >= 3'h3);
        dir_m  = m34 ? 8'h80 : 8'h00;
        data_m = 8'h00;
    endtask : do_reset

    task automatic results();
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {rd, wr, sw_sb, a20, tmr, pat} = 6'h00;
        {rst_n, hw_n} = 2'b01;
        addr = 18'h0_0000;
        wdata = 32'h0000_0000;
        be = 4'hF;
        mode = 3'h1;
        ext = 8'h5A;
        seed = 32'h0000_0056;
        n_errors = 0;
        checks_done = 0;
        do_reset(3'h1);
        rdchk(`DIR_IDX, 32'h0000_00FF); // direction reads ones
        rdchk(`DATA_IDX, port_exp()); // cleared data, pins shown
        rdchk(16'h0000, 32'h0000_0000); // unmapped place reads zero
        settle();
        chk(poe, 8'h00); // all pins input after reset
        // random direction, data and outside levels
        for (k = 0; k < 8; k++) begin
            r = xrand();
            wreg(`DIR_IDX, r[7:0]);
            dir_m = r[7:0];
            wreg(`DATA_IDX, r[15:8]);
            data_m = r[15:8];
            ext <= r[23:16];
            settle();
            chk(poe, dir_m); // direction one drives the pin
            chk(pout & poe, data_m & dir_m); // data on outputs
            rdchk(`DATA_IDX, port_exp()); // per-bit read source
        end
        // a write with byte lane 0 disabled is dropped
        be <= 4'h0;
        wreg(`DATA_IDX, ~data_m);
        be <= 4'hF;
        rdchk(`DATA_IDX, port_exp()); // data kept on lane-off write
        // software standby: writes acknowledged but not stored
        sw_sb <= 1'b1;
        wreg(`DIR_IDX, ~dir_m);
        wreg(`DATA_IDX, ~data_m);
        settle();
        chk(poe, dir_m); // outputs keep driving in standby
        rdchk(`DATA_IDX, port_exp()); // data kept in standby
        sw_sb <= 1'b0;
        // top pin source table over select, pwm, pattern, direction
        for (k = 0; k < 64; k++) begin
            if (k[2:0] == 3'h0 && k[3]) continue;
            r = xrand();
            tmr <= r[0];
            pat <= ~r[0];
            ext <= r[15:8];
            wreg(`DIR_IDX, {k[5], 7'h00});
            dir_m = {k[5], 7'h00};
            wreg(`MUX_IDX, {3'h0, k[4:0]});
            settle();
            own  = (k[2:0] != 3'h0) && !k[2];
            eoe  = own | k[5];
            eout = own ? tmr : (k[4] ? pat : data_m[7]);
            src  = own ? SRC_TIMER : (!k[5] ? SRC_INPUT :
                   (k[4] ? SRC_PATTERN : SRC_PORT));
            chk(poe[7], eoe); // timer owns on select 1 to 3
            if (eoe) chk(pout[7], eout); // timer, pattern, data
            chk(cap, (k[2] && !k[3]) ? lvl[7] : 1'b0); // capture
            rdchk(`STAT_IDX, {26'h000_0000, 1'b0, src}); // source
            rdchk(`MUX_IDX, {27'h000_0000, k[4:0]}); // select
        end
        // address modes: top pin locked to address bit 20
        do_reset(3'h3);
        settle();
        chk(poe, 8'h80); // top pin output in address modes
        wreg(`DIR_IDX, 8'h00);
        wreg(`MUX_IDX, 8'h01);
        wreg(`DATA_IDX, 8'hC3);
        data_m = 8'hC3;
        a20 <= 1'b1;
        settle();
        chk({poe[7], pout[7]}, 2'b11); // address bit drives pin
        @(posedge clk);
        a20 <= 1'b0;
        settle();
        chk({poe[7], pout[7]}, 2'b10); // follows address bit
        rdchk(`DATA_IDX, port_exp()); // top bit from latch
        // hardware standby floats pins and reloads registers
        @(posedge clk);
        hw_n <= 1'b0;
        settle();
        chk(poe, 8'h00); // pins float in hardware standby
        @(posedge clk);
        hw_n <= 1'b1;
        settle();
        data_m = 8'h00;
        chk(poe, 8'h80); // direction reloaded for the mode
        rdchk(`DATA_IDX, port_exp()); // data cleared again
        rdchk(`MUX_IDX, 32'h0000_0000); // select cleared
        // mode 4 is an address mode as well; status names the owner
        do_reset(3'h4);
        settle();
        chk(poe, 8'h80); // top pin output in mode 4
        wreg(`DIR_IDX, 8'h01);
        dir_m = 8'h81;
        settle();
        chk(poe, dir_m); // bit 7 write ignored
        rdchk(`STAT_IDX, {26'h000_0000, 1'b1, SRC_ADDR}); // owner
        rdchk(`DIR_IDX, 32'h0000_00FF); // still reads all ones
        results();
    end
endmodule : tb
